//--- hdl/dual_port_gpio_bank.sv
module dual_port_gpio_bank
    import gpio_bank_pkg::*;
(
    // Clock and reset
    input  wire logic              i_clock,
    input  wire logic              i_resetn,
    // AXI4-Lite write address
    input  wire logic              i_awvalid,
    output logic                   o_awready,
    input  wire logic [ADDR_W-1:0] i_awaddr,
    // AXI4-Lite write data
    input  wire logic              i_wvalid,
    output logic                   o_wready,
    input  wire logic [DATA_W-1:0] i_wdata,
    input  wire logic [3:0]        i_wstrb,
    // AXI4-Lite write response
    output logic                   o_bvalid,
    input  wire logic              i_bready,
    output logic      [1:0]        o_bresp,
    // AXI4-Lite read address
    input  wire logic              i_arvalid,
    output logic                   o_arready,
    input  wire logic [ADDR_W-1:0] i_araddr,
    // AXI4-Lite read data
    output logic                   o_rvalid,
    input  wire logic              i_rready,
    output logic      [DATA_W-1:0] o_rdata,
    output logic      [1:0]        o_rresp,
    // Port A pins
    input  wire logic [PORT_W-1:0] i_port_a_pin,
    output logic      [PORT_W-1:0] o_port_a_drive,
    output logic      [PORT_W-1:0] o_port_a_oe,
    output logic      [PORT_W-1:0] o_port_a_pullup,
    output logic      [PORT_W-1:0] o_port_a_wake,
    // Port B pins
    input  wire logic [PORT_W-1:0] i_port_b_pins,
    output logic      [PORT_W-1:0] o_port_b_drive,
    output logic      [PORT_W-1:0] o_port_b_oe,
    output logic      [PORT_W-1:0] o_port_b_pullup,
    output logic      [PORT_W-1:0] o_port_b_wake
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations

    logic              aw_held_reg;
    logic [ADDR_W-1:0] aw_addr_reg;
    logic              w_held_reg;
    logic [7:0]        w_data_reg;
    logic              w_lane0_reg;
    logic              bvalid_reg;
    logic [1:0]        bresp_reg;
    logic              rvalid_reg;
    logic [DATA_W-1:0] rdata_reg;
    logic [1:0]        rresp_reg;

    logic              aw_take;
    logic              w_take;
    logic              ar_take;
    logic              wr_fire;
    logic [4:0]        wr_idx;
    logic [4:0]        rd_idx;
    logic              wr_en;

    logic [7:0]        a_data_reg;
    logic [7:0]        a_dir_reg;
    logic [7:0]        a_pull_reg;
    logic [7:0]        a_in_en_reg;
    logic [7:0]        b_data_reg;
    logic [7:0]        b_dir_reg;
    logic [7:0]        b_pull_reg;
    logic [7:0]        b_in_en_reg;

    logic [7:0]        a_sync;
    logic [7:0]        b_sync;
    logic [7:0]        rd_byte;

    gpio_port_if a_if ();
    gpio_port_if b_if ();

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write channel

    // One write in flight: both channels stall until the response is taken
    assign o_awready = !aw_held_reg && !bvalid_reg;
    assign o_wready  = !w_held_reg && !bvalid_reg;
    assign aw_take   = i_awvalid && o_awready;
    assign w_take    = i_wvalid && o_wready;
    assign wr_fire   = aw_held_reg && w_held_reg && !bvalid_reg;
    assign wr_idx    = reg_index(aw_addr_reg);
    // Only byte lane 0 holds register bits; upper lanes are ignored
    assign wr_en     = wr_fire && w_lane0_reg && reg_mapped(wr_idx);

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            aw_held_reg <= 1'b0;
            aw_addr_reg <= '0;
        end else if (aw_take) begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= i_awaddr;
        end else if (wr_fire) begin
            aw_held_reg <= 1'b0;
        end
    end

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            w_held_reg  <= 1'b0;
            w_data_reg  <= '0;
            w_lane0_reg <= 1'b0;
        end else if (w_take) begin
            w_held_reg  <= 1'b1;
            w_data_reg  <= i_wdata[7:0];
            w_lane0_reg <= i_wstrb[0];
        end else if (wr_fire) begin
            w_held_reg  <= 1'b0;
        end
    end

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= reg_mapped(wr_idx) ? RESP_OKAY : RESP_SLVERR;
        end else if (bvalid_reg && i_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    assign o_bvalid = bvalid_reg;
    assign o_bresp  = bresp_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Register file

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            a_in_en_reg <= RST_IN_EN;                                  // [RULE_11]
            b_in_en_reg <= RST_IN_EN;                                  // [RULE_01]
        end else if (wr_en && wr_idx == IDX_A_IN_EN) begin
            a_in_en_reg <= w_data_reg;                                 // [RULE_11]
        end else if (wr_en && wr_idx == IDX_B_IN_EN) begin
            b_in_en_reg <= w_data_reg;                                 // [RULE_01]
        end
    end

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            a_data_reg <= RST_DATA;                                    // [RULE_03]
            b_data_reg <= RST_DATA;                                    // [RULE_08]
        end else if (wr_en && wr_idx == IDX_A_DATA) begin
            a_data_reg <= w_data_reg;                                  // [RULE_03]
        end else if (wr_en && wr_idx == IDX_B_DATA) begin
            b_data_reg <= w_data_reg;                                  // [RULE_08]
        end
    end

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            a_dir_reg <= RST_DIR;                                      // [RULE_04]
            b_dir_reg <= RST_DIR;                                      // [RULE_09]
        end else if (wr_en && wr_idx == IDX_A_DIR) begin
            a_dir_reg <= w_data_reg;                                   // [RULE_04]
        end else if (wr_en && wr_idx == IDX_B_DIR) begin
            b_dir_reg <= w_data_reg;                                   // [RULE_09]
        end
    end

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            a_pull_reg <= RST_PULL;                                    // [RULE_06]
            b_pull_reg <= RST_PULL;                                    // [RULE_10]
        end else if (wr_en && wr_idx == IDX_A_PULL) begin
            a_pull_reg <= w_data_reg;                                  // [RULE_06]
        end else if (wr_en && wr_idx == IDX_B_PULL) begin
            b_pull_reg <= w_data_reg;                                  // [RULE_10]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read channel

    assign o_arready = !rvalid_reg;
    assign ar_take   = i_arvalid && o_arready;
    assign rd_idx    = reg_index(i_araddr);

    // Data registers read back the pin level, not the stored value
    always_comb begin
        unique case (rd_idx)
            IDX_A_DATA: rd_byte = a_if.level;                          // [RULE_12]
            IDX_A_DIR:  rd_byte = a_dir_reg;
            IDX_A_PULL: rd_byte = a_pull_reg;
            IDX_B_DATA: rd_byte = b_if.level;                          // [RULE_12]
            IDX_B_DIR:  rd_byte = b_dir_reg;
            IDX_B_PULL: rd_byte = b_pull_reg;
            default:     rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= '0;
            rresp_reg  <= RESP_OKAY;
        end else if (ar_take) begin
            rvalid_reg <= 1'b1;
            rdata_reg  <= {24'h000000, rd_byte};
            rresp_reg  <= reg_mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_reg && i_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    assign o_rvalid = rvalid_reg;
    assign o_rdata  = rdata_reg;
    assign o_rresp  = rresp_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Ports

    assign a_if.data  = a_data_reg;
    assign a_if.dir   = a_dir_reg;
    assign a_if.pull  = a_pull_reg;
    assign a_if.in_en = a_in_en_reg;
    assign b_if.data  = b_data_reg;
    assign b_if.dir   = b_dir_reg;
    assign b_if.pull  = b_pull_reg;
    assign b_if.in_en = b_in_en_reg;

    assign o_port_a_wake = a_if.wake;
    assign o_port_b_wake = b_if.wake;

    gpio_sync3 u_a_sync (
        .i_clock (i_clock),
        .i_resetn(i_resetn),
        .i_pin   (i_port_a_pin),
        .o_level (a_sync)
    );

    gpio_sync3 u_b_sync (
        .i_clock (i_clock),
        .i_resetn(i_resetn),
        .i_pin   (i_port_b_pins),
        .o_level (b_sync)
    );

    gpio_port_pad #(
        .OPEN_DRAIN  (A_OPEN_DRAIN),
        .PULL_CAPABLE(A_PULL_CAPABLE)
    ) u_a_pad (
        .i_clock     (i_clock),
        .i_resetn    (i_resetn),
        .port        (a_if.pad),
        .i_sync_level(a_sync),
        .o_drive     (o_port_a_drive),
        .o_oe        (o_port_a_oe),
        .o_pullup    (o_port_a_pullup)
    );

    gpio_port_pad #(
        .OPEN_DRAIN  (B_OPEN_DRAIN),
        .PULL_CAPABLE(B_PULL_CAPABLE)
    ) u_b_pad (
        .i_clock     (i_clock),
        .i_resetn    (i_resetn),
        .port        (b_if.pad),
        .i_sync_level(b_sync),
        .o_drive     (o_port_b_drive),
        .o_oe        (o_port_b_oe),
        .o_pullup    (o_port_b_pullup)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_resetn);

    sequence both_taken_s;
        aw_take && w_take;
    endsequence

    sequence b_en_write_s;
        wr_en && wr_idx == IDX_B_IN_EN;
    endsequence

    sequence a_data_write_s;
        wr_en && wr_idx == IDX_A_DATA;
    endsequence

    b_en_store_a: assert property (b_en_write_s |=>               // [RULE_01]
        b_in_en_reg == $past(w_data_reg))
        else $error("port B input enable not stored");

    b_wake_block_a: assert property (1'b1 |=>                     // [RULE_02]
        (o_port_b_wake & ~$past(b_in_en_reg)) == 8'h00)
        else $error("wake from a disabled port B pin");

    a_data_store_a: assert property (a_data_write_s |=> ##1       // [RULE_03]
        o_port_a_drive == ($past(w_data_reg, 2) & ~A_OPEN_DRAIN))
        else $error("port A data write not driven");

    a_dir_oe_a: assert property (1'b1 |=>                         // [RULE_04]
        (o_port_a_oe & ~$past(a_dir_reg)) == 8'h00)
        else $error("port A input pin enabled as output");

    pin5_open_drain_a: assert property (                          // [RULE_05]
        a_dir_reg[5] && a_data_reg[5] |=> !o_port_a_oe[5] && !o_port_a_drive[5])
        else $error("port A pin 5 driven high");

    a_pull_input_a: assert property (1'b1 |=>                     // [RULE_06]
        (o_port_a_pullup & $past(a_dir_reg)) == 8'h00)
        else $error("pull-high active on an output pin");

    pin5_no_pull_a: assert property (!o_port_a_pullup[5])         // [RULE_07]
        else $error("pull-high on port A pin 5");

    b_drive_a: assert property (1'b1 |=>                          // [RULE_12]
        o_port_b_drive == $past(b_data_reg) && o_port_b_oe == $past(b_dir_reg))
        else $error("port B pad does not follow registers");

    b_pull_map_a: assert property (1'b1 |=>                       // [RULE_10]
        o_port_b_pullup == ($past(b_pull_reg) & ~$past(b_dir_reg)))
        else $error("port B pull-high mismatch");

    a_level_gate_a: assert property (1'b1 |=>                     // [RULE_13]
        (a_if.level & ~$past(a_in_en_reg)) == 8'h00)
        else $error("disabled port A pin shows a level");

    wr_resp_time_a: assert property (both_taken_s |=> ##1         // [RULE_08]
        o_bvalid)
        else $error("write response late");

endmodule : dual_port_gpio_bank

//--- hdl/gpio_bank_pkg.sv
// Function
// [RULE_01] Write-only port B input enable register, one bit per pin, resets to all ones.
// [RULE_02] A cleared port B input enable bit blocks wake-up events from that pin.
// [RULE_03] Port A data register, eight bits, readable and writable, resets to zero.
// [RULE_04] Port A direction register, 1 is output, resets to zero so pins start as inputs.
// [RULE_05] Port A pin 5 only pulls low; output with data 1 leaves it tri-stated.
// [RULE_06] Port A pull-high enable register, resets to zero, acts only in input mode.
// [RULE_07] Port A pin 5 has no pull-up; its pull-high enable bit does nothing.
// [RULE_08] Port B data register, eight bits, readable and writable.
// [RULE_09] Port B direction register, 1 is output, resets to zero.
// [RULE_10] Port B pull-high enable register, 1 enables pull-high, resets to zero.
// [RULE_11] Write-only port A input enable register gating digital input and wake-up.
// [RULE_12] Output pins drive their data bit; data reads return enabled pins' sampled levels.
// [RULE_13] A pin with input disabled shows zero to sampling and wake-up logic.
package gpio_bank_pkg;

    localparam int          PORT_W          = 8;
    localparam int          ADDR_W          = 7;
    localparam int          DATA_W          = 32;

    // Register indices; byte address is four times the index
    localparam logic [4:0]  IDX_A_IN_EN     = 5'h0d;
    localparam logic [4:0]  IDX_B_IN_EN     = 5'h0e;
    localparam logic [4:0]  IDX_A_DATA      = 5'h10;
    localparam logic [4:0]  IDX_A_DIR       = 5'h11;
    localparam logic [4:0]  IDX_A_PULL      = 5'h12;
    localparam logic [4:0]  IDX_B_DATA      = 5'h14;
    localparam logic [4:0]  IDX_B_DIR       = 5'h15;
    localparam logic [4:0]  IDX_B_PULL      = 5'h16;

    // Reset values
    localparam logic [7:0]  RST_IN_EN       = 8'hff;
    localparam logic [7:0]  RST_DATA        = 8'h00;
    localparam logic [7:0]  RST_DIR         = 8'h00;
    localparam logic [7:0]  RST_PULL        = 8'h00;

    // Pin capability masks
    localparam logic [7:0]  A_OPEN_DRAIN    = 8'h20;
    localparam logic [7:0]  A_PULL_CAPABLE  = 8'hdf;
    localparam logic [7:0]  B_OPEN_DRAIN    = 8'h00;
    localparam logic [7:0]  B_PULL_CAPABLE  = 8'hff;

    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;

    function automatic logic [4:0] reg_index(input logic [ADDR_W-1:0] addr);
        return addr[6:2];
    endfunction : reg_index

    function automatic logic reg_mapped(input logic [4:0] idx);
        return idx inside {IDX_A_IN_EN, IDX_B_IN_EN, IDX_A_DATA, IDX_A_DIR,
                           IDX_A_PULL, IDX_B_DATA, IDX_B_DIR, IDX_B_PULL};
    endfunction : reg_mapped

endpackage : gpio_bank_pkg

//--- hdl/gpio_port_if.sv
interface gpio_port_if;
    import gpio_bank_pkg::*;
    logic [PORT_W-1:0] data;
    logic [PORT_W-1:0] dir;
    logic [PORT_W-1:0] pull;
    logic [PORT_W-1:0] in_en;
    logic [PORT_W-1:0] level;
    logic [PORT_W-1:0] wake;

    modport regs (output data, dir, pull, in_en, input level, wake);
    modport pad  (input data, dir, pull, in_en, output level, wake);
endinterface : gpio_port_if

//--- hdl/gpio_sync3.sv
module gpio_sync3
    import gpio_bank_pkg::*;
(
    // Clock and reset
    input  wire logic              i_clock,
    input  wire logic              i_resetn,
    // Pins and filtered level
    input  wire logic [PORT_W-1:0] i_pin,
    output logic      [PORT_W-1:0] o_level
);
    logic [PORT_W-1:0] s1_reg;
    logic [PORT_W-1:0] s2_reg;
    logic [PORT_W-1:0] s3_reg;
    logic [PORT_W-1:0] agree;

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
        end else begin
            s1_reg <= i_pin;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // A change counts only once the last two stages agree
    assign agree = ~(s2_reg ^ s3_reg);

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            o_level <= '0;
        end else begin
            o_level <= (o_level & ~agree) | (s3_reg & agree);
        end
    end
endmodule : gpio_sync3

//--- hdl/gpio_port_pad.sv
module gpio_port_pad
    import gpio_bank_pkg::*;
#(
    parameter logic [PORT_W-1:0] OPEN_DRAIN   = 8'h00,
    parameter logic [PORT_W-1:0] PULL_CAPABLE = 8'hff
) (
    // Clock and reset
    input  wire logic              i_clock,
    input  wire logic              i_resetn,
    // Register side
    gpio_port_if.pad               port,
    input  wire logic [PORT_W-1:0] i_sync_level,
    // Pad side
    output logic      [PORT_W-1:0] o_drive,
    output logic      [PORT_W-1:0] o_oe,
    output logic      [PORT_W-1:0] o_pullup
);
    logic [PORT_W-1:0] gated;

    assign gated = i_sync_level & port.in_en;                          // [RULE_13]

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            o_drive  <= '0;
            o_oe     <= '0;
            o_pullup <= '0;
        end else begin
            o_drive  <= port.data & ~OPEN_DRAIN;                       // [RULE_12] [RULE_05]
            o_oe     <= port.dir & (~OPEN_DRAIN | ~port.data);         // [RULE_05]
            o_pullup <= port.pull & ~port.dir & PULL_CAPABLE;          // [RULE_06] [RULE_07]
        end
    end

    // Disabled pins neither report a level nor raise a wake event
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            port.level <= '0;
            port.wake  <= '0;
        end else begin
            port.level <= gated;
            port.wake  <= (gated ^ port.level) & port.in_en;           // [RULE_02] [RULE_11]
        end
    end
endmodule : gpio_port_pad

//--- bench/gpio_pins_model.sv
module gpio_pins_model
    import gpio_bank_pkg::*;
(
    // Clock
    input  wire logic              i_clock,
    // Pad controls from the bank
    input  wire logic [PORT_W-1:0] i_drive,
    input  wire logic [PORT_W-1:0] i_oe,
    input  wire logic [PORT_W-1:0] i_pullup,
    // Board-side sources
    input  wire logic [PORT_W-1:0] i_ext_en,
    input  wire logic [PORT_W-1:0] i_ext_val,
    // Resolved pin levels
    output logic      [PORT_W-1:0] o_pin
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [PORT_W-1:0] float_q = 8'h00;

    // An undriven pin must not look like a stable level
    always @(posedge i_clock) begin
        float_q <= ~float_q;
    end

    always_comb begin
        for (int i = 0; i < PORT_W; i++) begin
            if (i_oe[i]) begin
                o_pin[i] = i_drive[i];
            end else if (i_pullup[i]) begin
                o_pin[i] = 1'b1;
            end else if (i_ext_en[i]) begin
                o_pin[i] = i_ext_val[i];
            end else begin
                o_pin[i] = float_q[i];
            end
        end
    end
endmodule : gpio_pins_model

//--- bench/dual_port_gpio_bank_tb.sv
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin err_total++; \
    $display("BAD %s exp %h got %h", nm, e, g); end end

module dual_port_gpio_bank_tb;
    import gpio_bank_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic              i_clock = 1'b0;
    logic              i_resetn = 1'b0;
    logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic              arvalid = 1'b0, rready = 1'b0;
    logic              wclr_a = 1'b0, wclr_b = 1'b0;
    logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
    logic [DATA_W-1:0] wdata = '0;
    logic [3:0]        wstrb = 4'hf;
    logic              awready, wready, bvalid, arready, rvalid;
    logic [1:0]        bresp, rresp;
    logic [DATA_W-1:0] rdata;
    logic [PORT_W-1:0] pin_a, drv_a, oe_a, pu_a, wk_a, pin_b, drv_b, oe_b, pu_b, wk_b;
    logic [PORT_W-1:0] ext_en_a = 8'hff, ext_a = 8'h3c, ext_en_b = 8'hff, ext_b = 8'hc3;
    logic [PORT_W-1:0] wacc_a = '0, wacc_b = '0;
    int                err_total = 0;
    int                comparisons = 0;

    always #10 i_clock = ~i_clock;

    // Single writer of the accumulators; the scenario clears them through a flag
    always @(posedge i_clock) begin
        wacc_a <= wclr_a ? 8'h00 : (wacc_a | wk_a);
        wacc_b <= wclr_b ? 8'h00 : (wacc_b | wk_b);
    end

    dual_port_gpio_bank dut_u (
        .i_clock(i_clock), .i_resetn(i_resetn),
        .i_awvalid(awvalid), .o_awready(awready), .i_awaddr(awaddr),
        .i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata), .i_wstrb(wstrb),
        .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp),
        .i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr),
        .o_rvalid(rvalid), .i_rready(rready), .o_rdata(rdata), .o_rresp(rresp),
        .i_port_a_pin(pin_a), .o_port_a_drive(drv_a), .o_port_a_oe(oe_a),
        .o_port_a_pullup(pu_a), .o_port_a_wake(wk_a),
        .i_port_b_pins(pin_b), .o_port_b_drive(drv_b), .o_port_b_oe(oe_b),
        .o_port_b_pullup(pu_b), .o_port_b_wake(wk_b)
    );

    gpio_pins_model pins_a_u (.i_clock(i_clock), .i_drive(drv_a), .i_oe(oe_a),
        .i_pullup(pu_a), .i_ext_en(ext_en_a), .i_ext_val(ext_a), .o_pin(pin_a));
    gpio_pins_model pins_b_u (.i_clock(i_clock), .i_drive(drv_b), .i_oe(oe_b),
        .i_pullup(pu_b), .i_ext_en(ext_en_b), .i_ext_val(ext_b), .o_pin(pin_b));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict;
        $display("Checks %0d, mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : give_verdict

    task automatic bound(input int n);
        if (n > 60) begin
            err_total++;
            $display("BAD bus wait exp handshake got timeout");
            give_verdict();
        end
    endtask : bound

    // Handshakes are judged half a cycle before the edge that takes them
    task automatic axi_wr(input logic [4:0] idx, input logic [7:0] d, output logic [1:0] r);
        int  n;
        logic pa, pw, ta, tw;
        @(posedge i_clock);
        awvalid <= 1'b1;
        awaddr <= {idx, 2'b00};
        wvalid <= 1'b1;
        wdata <= {24'h000000, d};
        bready <= 1'b1;
        pa = 1;
        pw = 1;
        n = 0;
        while (pa || pw) begin
            @(negedge i_clock);
            bound(++n);
            ta = pa && awready;
            tw = pw && wready;
            @(posedge i_clock);
            if (ta) begin awvalid <= 1'b0; pa = 0; end
            if (tw) begin wvalid <= 1'b0; pw = 0; end
        end
        do begin @(negedge i_clock); bound(++n); end while (bvalid !== 1'b1);
        r = bresp;
        @(posedge i_clock);
        bready <= 1'b0;
    endtask : axi_wr

    task automatic axi_rd(input logic [4:0] idx, output logic [DATA_W-1:0] d,
                          output logic [1:0] r);
        int n;
        @(posedge i_clock);
        arvalid <= 1'b1;
        araddr <= {idx, 2'b00};
        rready <= 1'b1;
        n = 0;
        do begin @(negedge i_clock); bound(++n); end while (arready !== 1'b1);
        @(posedge i_clock);
        arvalid <= 1'b0;
        do begin @(negedge i_clock); bound(++n); end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        @(posedge i_clock);
        rready <= 1'b0;
    endtask : axi_rd

    task automatic wr(input logic [4:0] idx, input logic [7:0] d);
        logic [1:0] r;
        axi_wr(idx, d, r);
        `CHK("write resp", RESP_OKAY, r)
    endtask : wr

    task automatic rd_chk(input logic [4:0] idx, input logic [7:0] e);
        logic [DATA_W-1:0] d;
        logic [1:0]        r;
        axi_rd(idx, d, r);
        `CHK("read resp", RESP_OKAY, r)
        `CHK("read data", {24'h000000, e}, d)
    endtask : rd_chk

    ////////////////////////////////////////////////////////////////////////////////
    logic [4:0]        idx_tab[8] = '{IDX_A_IN_EN, IDX_B_IN_EN, IDX_A_DATA, IDX_A_DIR,
                                      IDX_A_PULL, IDX_B_DATA, IDX_B_DIR, IDX_B_PULL};
    logic [7:0]        exp_tab[8] = '{8'h00, 8'h00, 8'h3c, 8'h00, 8'h00, 8'hc3, 8'h00, 8'h00};
    logic [DATA_W-1:0] rd_v;
    logic [1:0]        rs;

    initial begin
        repeat (2) @(posedge i_clock);
        i_resetn <= 1'b1;
        repeat (8) @(posedge i_clock);
        #1;
        `CHK("pad a", 24'h000000, {drv_a, oe_a, pu_a})
        `CHK("pad b", 24'h000000, {drv_b, oe_b, pu_b})
        for (int i = 0; i < 8; i++) begin
            rd_chk(idx_tab[i], exp_tab[i]);
        end
        axi_wr(5'h00, 8'h55, rs);
        `CHK("unmapped write", RESP_SLVERR, rs)
        axi_rd(5'h00, rd_v, rs);
        `CHK("unmapped read", RESP_SLVERR, rs)
        // Lane 0 strobe low: the write is answered but changes nothing
        wstrb <= 4'he;
        wr(IDX_A_DIR, 8'h33);
        wstrb <= 4'hf;
        rd_chk(IDX_A_DIR, 8'h00);
        // Open-drain pin stays released when asked to drive high
        ext_en_a <= 8'h00;
        wr(IDX_A_DIR, 8'hff);
        wr(IDX_A_DATA, 8'hff);
        repeat (2) @(posedge i_clock);
        `CHK("a drive oe", 16'hdfdf, {drv_a, oe_a})
        rd_chk(IDX_A_DIR, 8'hff);
        wr(IDX_A_DATA, 8'h00);
        repeat (2) @(posedge i_clock);
        `CHK("a drive oe low", 16'h00ff, {drv_a, oe_a})
        wr(IDX_A_PULL, 8'hff);
        wr(IDX_A_DIR, 8'h0f);
        repeat (2) @(posedge i_clock);
        `CHK("a pull mixed", 8'hd0, pu_a)
        wr(IDX_A_DIR, 8'h00);
        repeat (2) @(posedge i_clock);
        `CHK("a pull input", 8'hdf, pu_a)
        rd_chk(IDX_A_PULL, 8'hff);
        wr(IDX_A_PULL, 8'h00);
        ext_en_a <= 8'hff;
        wr(IDX_B_DIR, 8'hff);
        wr(IDX_B_DATA, 8'ha5);
        repeat (2) @(posedge i_clock);
        `CHK("b drive oe", 16'ha5ff, {drv_b, oe_b})
        rd_chk(IDX_B_DIR, 8'hff);
        wr(IDX_B_DIR, 8'h00);
        wr(IDX_B_PULL, 8'hff);
        repeat (2) @(posedge i_clock);
        `CHK("b pull", 8'hff, pu_b)
        rd_chk(IDX_B_PULL, 8'hff);
        wr(IDX_B_PULL, 8'h00);
        // Disabled inputs must read zero and stay silent
        wr(IDX_B_IN_EN, 8'h0f);
        ext_b <= 8'hff;
        repeat (8) @(posedge i_clock);
        rd_chk(IDX_B_DATA, 8'h0f);
        wclr_b <= 1'b1;
        ext_b <= 8'h7e;
        @(posedge i_clock);
        wclr_b <= 1'b0;
        repeat (10) @(posedge i_clock);
        `CHK("b wake", 8'h01, wacc_b)
        wr(IDX_A_IN_EN, 8'hf0);
        ext_a <= 8'hff;
        repeat (8) @(posedge i_clock);
        rd_chk(IDX_A_DATA, 8'hf0);
        wclr_a <= 1'b1;
        ext_a <= 8'h7e;
        @(posedge i_clock);
        wclr_a <= 1'b0;
        repeat (10) @(posedge i_clock);
        `CHK("a wake", 8'h80, wacc_a)
        give_verdict();
    end
endmodule : dual_port_gpio_bank_tb
